// [design/pen_regs.svh]
// Register offsets, field positions, reset values and counts for the partition enable register bank.
`ifndef PEN_REGS_SVH
`define PEN_REGS_SVH
`define PEN_ADDR_W 12
`define PEN_OFS_ENABLE 12'h300
`define PEN_OFS_DISABLE 12'h310
`define PEN_OFS_BITMAP 12'h320
`define PEN_OFS_NARROW 12'h600
`define PEN_PART_MSB 15
`define PEN_NRW_FLAG_BIT 16
`define PEN_GROUP_MASK 16'hFFE0
`define PEN_GROUP_SIZE 32
`define PEN_PART0_RESET 1'b1
`define PEN_MAP_RESET 16'h0000
`define PEN_NUM_SPACES 4
`endif

// [design/pen_pkg.sv]
// Types shared by the partition enable and narrowing register bank.
package pen_pkg;
    // Address space that an access arrives in.
    typedef enum logic [1:0] {
        PEN_SECURE = 2'h0,
        PEN_NONSECURE = 2'h1,
        PEN_ROOT = 2'h2,
        PEN_REALM = 2'h3
    } pen_space_t;

    // One register access from the memory-mapped frame.
    typedef struct packed {
        logic valid;
        logic write;
        pen_space_t space;
        logic [11:0] addr;
        logic [31:0] wdata;
    } pen_req_t;

    // Contents of one space's selection register.
    typedef struct packed {
        logic [15:0] index;
        logic internal;
        logic [3:0] inst;
    } pen_sel_t;

    // Error events for the error status register.
    typedef struct packed {
        logic range;
        logic unexpected;
        pen_space_t space;
    } pen_err_t;

    // Operation on one space's enable state.
    typedef struct packed {
        logic set_one;
        logic clr_one;
        logic wr_group;
        logic [3:0] inst;
        logic [15:0] sel_index;
        logic [15:0] cmd_index;
        logic [31:0] group;
    } pen_store_op_t;

    // Operation on one space's narrowing table.
    typedef struct packed {
        logic wr;
        logic [15:0] req_id;
        logic [16:0] wdata;
    } pen_map_op_t;

    // Registered response state of the top level.
    typedef struct packed {
        logic rsp_valid;
        logic [31:0] rdata;
        pen_err_t err;
    } pen_top_state_t;
endpackage

// [design/pen_enable_store.sv]
// Per-partition enable state of one address space, for every resource instance.
`timescale 1ns/100ps
`include "pen_regs.svh"
module pen_enable_store #(
    parameter int NPART = 64,
    parameter int NRIS = 1,
    parameter int HIGHEST_PART = 63
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Operation and read back
    input wire pen_pkg::pen_store_op_t op,
    output logic [31:0] group_rd
);
    typedef struct packed {
        logic [NRIS*NPART-1:0] en;
    } pen_store_state_t;

    pen_store_state_t st_ff;
    pen_store_state_t nxt_st;
    logic [15:0] base;
    logic inst_ok;

    // Group base is the selection index with its low five bits cleared.
    assign base = op.sel_index & `PEN_GROUP_MASK;
    // Instance numbers beyond the implemented count read zero and ignore writes.
    assign inst_ok = int'(op.inst) < NRIS;

    // Read back the 32 flags of the selected group; missing partitions read 0.
    generate
        for (genvar i = 0; i < `PEN_GROUP_SIZE; i++) begin : g_rd
            localparam logic [16:0] OFS = 17'(i);
            logic [16:0] part;
            assign part = {1'b0, base} + OFS;
            assign group_rd[i] = (inst_ok && int'(part) <= HIGHEST_PART && int'(part) < NPART) ?
                st_ff.en[int'(op.inst) * NPART + int'(part)] : 1'b0;
        end
    endgenerate

    // All three registers act on the same enable bits.
    always_comb begin
        int p;
        p = 0;
        nxt_st = st_ff;
        if (inst_ok) begin
            if (op.wr_group) begin
                for (int i = 0; i < `PEN_GROUP_SIZE; i++) begin
                    p = int'(base) + i;
                    if (p <= HIGHEST_PART && p < NPART) begin
                        nxt_st.en[int'(op.inst) * NPART + p] = op.group[i];
                    end
                end
            end
            p = int'(op.cmd_index);
            if (op.set_one && p <= HIGHEST_PART && p < NPART) begin
                nxt_st.en[int'(op.inst) * NPART + p] = 1'b1;
            end
            if (op.clr_one && p <= HIGHEST_PART && p < NPART) begin
                nxt_st.en[int'(op.inst) * NPART + p] = 1'b0;
            end
        end
    end

    // Partition 0 of every instance comes out of reset enabled.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_ff <= '0;
            for (int r = 0; r < NRIS; r++) begin
                st_ff.en[r * NPART] <= `PEN_PART0_RESET;
            end
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule // pen_enable_store

// [design/pen_narrow_map.sv]
// Requested-to-narrowed partition number table of one address space.
`timescale 1ns/100ps
`include "pen_regs.svh"
module pen_narrow_map #(
    parameter int NPART = 64,
    parameter int NARROW_MAX = 15
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Operation and read back
    input wire pen_pkg::pen_map_op_t op,
    output logic [15:0] rd_id,
    output logic rd_flag,
    output logic range_bad
);
    typedef struct packed {
        logic [NPART*16-1:0] map;
        logic flag;
    } pen_map_state_t;

    pen_map_state_t st_ff;
    pen_map_state_t nxt_st;
    logic req_ok;

    assign req_ok = int'(op.req_id) < NPART;
    // A write is refused when the flag is clear or the identifier is too large.
    assign range_bad = !op.wdata[`PEN_NRW_FLAG_BIT] ||
        int'(op.wdata[`PEN_PART_MSB:0]) > NARROW_MAX;
    // Read returns the current association of the selected requested number.
    assign rd_id = req_ok ? st_ff.map[int'(op.req_id) * 16 +: 16] : 16'h0000;
    assign rd_flag = st_ff.flag;

    // Record the association only for good writes; the flag always follows the write.
    always_comb begin
        nxt_st = st_ff;
        if (op.wr) begin
            nxt_st.flag = op.wdata[`PEN_NRW_FLAG_BIT];
            if (!range_bad && req_ok) begin
                nxt_st.map[int'(op.req_id) * 16 +: 16] = op.wdata[`PEN_PART_MSB:0];
            end
        end
    end

    // Table and flag registers.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_ff.map <= {NPART{`PEN_MAP_RESET}};
            st_ff.flag <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule // pen_narrow_map

// [design/pen_top.sv]
// Partition enable, enable bitmap and narrowing register bank for four address spaces.
`timescale 1ns/100ps
`include "pen_regs.svh"
module pen_top #(
    parameter int NPART = 64,
    parameter int NRIS = 1,
    parameter int HIGHEST_PART = 63,
    parameter int NARROW_MAX = 15,
    parameter bit ON_OFF_OK = 1'b1,
    parameter bit VERSION_OK = 1'b1,
    parameter bit HAS_NRW = 1'b1,
    parameter bit FOUR_SPACES = 1'b1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Register access from the feature page frames
    input wire pen_pkg::pen_req_t req,
    output logic rsp_valid,
    output logic [31:0] rsp_rdata,
    // Selection register of each space
    input wire pen_pkg::pen_sel_t sel [`PEN_NUM_SPACES],
    // Error events towards the error status register
    output pen_pkg::pen_err_t err
);
    pen_pkg::pen_top_state_t st_ff;
    pen_pkg::pen_top_state_t nxt_st;
    pen_pkg::pen_store_op_t store_op [`PEN_NUM_SPACES];
    pen_pkg::pen_map_op_t map_op [`PEN_NUM_SPACES];
    logic [31:0] group_rd [`PEN_NUM_SPACES];
    logic [15:0] map_rd_id [`PEN_NUM_SPACES];
    logic map_rd_flag [`PEN_NUM_SPACES];
    logic map_range_bad [`PEN_NUM_SPACES];
    logic space_ok;
    logic endis_ok;
    logic hit_enable;
    logic hit_disable;
    logic hit_bitmap;
    logic hit_narrow;
    logic wr;
    logic narrow_sel_err;

    // Root and realm frames exist only with the four-space option.
    assign space_ok = (req.space == pen_pkg::PEN_SECURE) || (req.space == pen_pkg::PEN_NONSECURE) ||
        FOUR_SPACES;
    assign endis_ok = ON_OFF_OK && VERSION_OK;

    // Address decode of the four registers; absent ones fall through as reserved.
    assign hit_enable = req.valid && space_ok && endis_ok && req.addr == `PEN_OFS_ENABLE;
    assign hit_disable = req.valid && space_ok && endis_ok && req.addr == `PEN_OFS_DISABLE;
    assign hit_bitmap = req.valid && space_ok && endis_ok && req.addr == `PEN_OFS_BITMAP;
    assign hit_narrow = req.valid && space_ok && HAS_NRW && req.addr == `PEN_OFS_NARROW;
    assign wr = req.write;
    // The narrowing register expects a requested number in the selection.
    assign narrow_sel_err = hit_narrow && sel[req.space].internal;

    // One enable store and one narrowing table per space; only the addressed space sees writes.
    generate
        for (genvar g = 0; g < `PEN_NUM_SPACES; g++) begin : g_space
            logic mine;
            assign mine = req.space == pen_pkg::pen_space_t'(g);
            // With or without narrowing the selection index is used as the partition to address.
            assign store_op[g].sel_index = sel[g].index;
            assign store_op[g].inst = sel[g].inst;
            assign store_op[g].cmd_index = req.wdata[`PEN_PART_MSB:0];
            assign store_op[g].group = req.wdata;
            assign store_op[g].set_one = mine && hit_enable && wr;
            assign store_op[g].clr_one = mine && hit_disable && wr;
            assign store_op[g].wr_group = mine && hit_bitmap && wr;
            assign map_op[g].req_id = sel[g].index;
            assign map_op[g].wdata = req.wdata[`PEN_NRW_FLAG_BIT:0];
            assign map_op[g].wr = mine && hit_narrow && wr && !sel[g].internal;

            pen_enable_store #(
                .NPART(NPART),
                .NRIS(NRIS),
                .HIGHEST_PART(HIGHEST_PART)
            ) u_store (
                .clk_sys(clk_sys),
                .rst(rst),
                .op(store_op[g]),
                .group_rd(group_rd[g])
            );

            pen_narrow_map #(
                .NPART(NPART),
                .NARROW_MAX(NARROW_MAX)
            ) u_map (
                .clk_sys(clk_sys),
                .rst(rst),
                .op(map_op[g]),
                .rd_id(map_rd_id[g]),
                .rd_flag(map_rd_flag[g]),
                .range_bad(map_range_bad[g])
            );
        end
    endgenerate

    // Response data and error pulses for the access taken this cycle.
    always_comb begin
        nxt_st = st_ff;
        nxt_st.rsp_valid = req.valid;
        nxt_st.rdata = 32'h0000_0000;
        nxt_st.err.range = 1'b0;
        nxt_st.err.unexpected = 1'b0;
        nxt_st.err.space = req.space;
        if (!wr && hit_bitmap) begin
            nxt_st.rdata = group_rd[req.space];
        end
        if (!wr && hit_narrow) begin
            nxt_st.rdata = {15'h0000, map_rd_flag[req.space], map_rd_id[req.space]};
        end
        if (narrow_sel_err) begin
            nxt_st.err.unexpected = 1'b1;
        end
        if (hit_narrow && wr && !sel[req.space].internal && map_range_bad[req.space]) begin
            nxt_st.err.range = 1'b1;
        end
    end

    // Response and error registers.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rsp_valid = st_ff.rsp_valid;
    assign rsp_rdata = st_ff.rdata;
    assign err = st_ff.err;
endmodule // pen_top

// [verif/pen_top_sva.sv]
// Concurrent checks on the ports of the partition enable register bank.
`timescale 1ns/100ps
module pen_sva #(
    parameter int NARROW_MAX = 15
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Access, selection and answer
    input wire pen_pkg::pen_req_t req,
    input wire pen_pkg::pen_sel_t sel [4],
    input wire logic rsp_valid,
    input wire logic [31:0] rsp_rdata,
    input wire pen_pkg::pen_err_t err
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Narrowing accesses, their selection flag and bad written values.
    wire nrw = req.valid && req.addr == 12'h600;
    wire unx = sel[req.space].internal;
    wire bad = !req.wdata[16] || req.wdata[15:0] > NARROW_MAX;
    sequence s_nrw_wr;
        nrw && req.write && !unx;
    endsequence
    sequence s_nrw_rd;
        nrw && !req.write && req.space == $past(req.space, 2);
    endsequence
    property p_rsp; req.valid |=> rsp_valid; endproperty
    a_rsp: assert property (p_rsp) else $error("access not answered");
    property p_idle; !req.valid |=> !rsp_valid && rsp_rdata == 32'h0 && !err.range && !err.unexpected; endproperty
    a_idle: assert property (p_idle) else $error("output without access");
    property p_raz;
        req.valid && (req.write || req.addr == 12'h300 || req.addr == 12'h310) |=> rsp_rdata == 32'h0;
    endproperty
    a_raz: assert property (p_raz) else $error("read data not zero");
    property p_unx; nrw && unx |=> err.unexpected && !err.range; endproperty
    a_unx: assert property (p_unx) else $error("missing unexpected error");
    property p_rng; s_nrw_wr and (bad) |=> err.range && !err.unexpected; endproperty
    a_rng: assert property (p_rng) else $error("missing range error");
    property p_ok; nrw && req.write && !unx && !bad |=> !err.range && !err.unexpected; endproperty
    a_ok: assert property (p_ok) else $error("error on good write");
    property p_spc; req.valid |=> err.space == $past(req.space); endproperty
    a_spc: assert property (p_spc) else $error("wrong error space");
    property p_flag; s_nrw_wr ##2 s_nrw_rd |=> rsp_rdata[16] == $past(req.wdata[16], 3); endproperty
    a_flag: assert property (p_flag) else $error("flag not last written");
endmodule // pen_sva
bind pen_top pen_sva #(.NARROW_MAX(NARROW_MAX)) u_sva (.clk_sys(clk_sys), .rst(rst), .req(req),
    .sel(sel), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .err(err));

// [verif/tb.sv]
// Self-checking testbench of the partition enable register bank.
`timescale 1ns/100ps
module tb;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    pen_pkg::pen_req_t req = '0;
    pen_pkg::pen_sel_t sel [4] = '{default: '0};
    logic rsp_valid;
    logic [31:0] rsp_rdata;
    pen_pkg::pen_err_t err;
    logic [31:0] rd;
    logic [31:0] ev;
    int err_total = 0;
    int checks = 0;
    // Design with its default sizes.
    pen_top DUT (.clk_sys(clk_sys), .rst(rst), .req(req), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .sel(sel), .err(err));
    // Clock of 8 ns period.
    always #4 clk_sys = ~clk_sys;
    // Compares one value and counts it.
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One access held for a single edge; the answer is taken one cycle later.
    task automatic acc(input logic w, input logic [1:0] s, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        req <= '{1'b1, w, pen_pkg::pen_space_t'(s), a, d};
        @(posedge clk_sys);
        req.valid <= 1'b0;
        #1;
        chk("rsp_valid", 32'h1, {31'h0, rsp_valid});
        rd = rsp_rdata;
        ev = {30'h0, err.range, err.unexpected};
    endtask
    // Reads one register and compares it.
    task automatic rdc(input logic [1:0] s, input logic [11:0] a, input logic [31:0] e, input string nm);
        acc(1'b0, s, a, 32'h0);
        chk(nm, e, rd);
    endtask
    // Reset state of every space.
    task automatic t_reset;
        for (int s = 0; s < 4; s++) begin
            rdc(2'(s), 12'h320, 32'h1, "bitmap");
            rdc(2'(s), 12'h600, 32'h0, "map");
        end
    endtask
    // Enable and disable commands against the bitmap.
    task automatic t_enable;
        @(posedge clk_sys) sel[1] <= '{16'h0025, 1'b1, 4'h0};
        acc(1'b1, 2'h1, 12'h300, 32'hFFFF_0027);
        rdc(2'h1, 12'h300, 32'h0, "enable_rd");
        rdc(2'h1, 12'h320, 32'h80, "bitmap");
        acc(1'b1, 2'h1, 12'h300, 32'h25);
        acc(1'b1, 2'h1, 12'h310, 32'h27);
        rdc(2'h1, 12'h320, 32'h20, "bitmap");
        acc(1'b1, 2'h1, 12'h300, 32'h60);
        rdc(2'h1, 12'h320, 32'h20, "bitmap");
        @(posedge clk_sys) sel[0] <= '{16'h0021, 1'b0, 4'h0};
        rdc(2'h0, 12'h320, 32'h0, "other");
        @(posedge clk_sys) sel[1] <= '{16'h0021, 1'b0, 4'h1};
        rdc(2'h1, 12'h320, 32'h0, "inst");
    endtask
    // Bitmap written whole, then touched by a command.
    task automatic t_bitmap;
        @(posedge clk_sys) sel[2] <= '{16'h001F, 1'b0, 4'h0};
        acc(1'b1, 2'h2, 12'h320, 32'hA5A5_5A5A);
        rdc(2'h2, 12'h320, 32'hA5A5_5A5A, "bitmap");
        acc(1'b1, 2'h2, 12'h300, 32'h0);
        rdc(2'h2, 12'h320, 32'hA5A5_5A5B, "bitmap");
        @(posedge clk_sys) sel[2] <= '{16'h0040, 1'b0, 4'h0};
        rdc(2'h2, 12'h320, 32'h0, "bitmap_hi");
        rdc(2'h2, 12'h304, 32'h0, "unmapped");
    endtask
    // Narrowing map writes, bad writes and selection errors.
    task automatic t_narrow;
        @(posedge clk_sys) sel[3] <= '{16'h0005, 1'b0, 4'h0};
        acc(1'b1, 2'h3, 12'h600, 32'h0001_0007);
        chk("err", 32'h0, ev);
        rdc(2'h3, 12'h600, 32'h0001_0007, "map");
        acc(1'b1, 2'h3, 12'h600, 32'h0001_0010);
        chk("range", 32'h2, ev);
        acc(1'b1, 2'h3, 12'h600, 32'h0000_0003);
        chk("range", 32'h2, ev);
        rdc(2'h3, 12'h600, 32'h0000_0007, "map");
        rdc(2'h0, 12'h600, 32'h0, "other_map");
        @(posedge clk_sys) sel[3] <= '{16'h0005, 1'b1, 4'h0};
        acc(1'b0, 2'h3, 12'h600, 32'h0);
        chk("unexpected", 32'h1, ev);
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic results;
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Main sequence after eight cycles of reset.
    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset;
        t_enable;
        t_bitmap;
        t_narrow;
        results;
    end
    // Cuts a hang short well after the expected run of about 0.6 us.
    initial begin
        #20000;
        err_total++;
        results;
    end
endmodule // tb
